// ==== design/gbd_bus_command_decoder.sv ====
// Device-side bus command decoder: addressing, remote/local, poll, clear and trigger
`timescale 1ns/1ps
module gbd_bus_command_decoder (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Bus management and data lines, active low
   input wire logic atn_n,
   input wire logic ren_n,
   input wire logic ifc_n,
   input wire logic eoi_n_i,
   input wire logic [7:0] dio_n_i,
   // Byte accepted by the handshake logic
   input wire logic byte_valid,
   input wire logic byte_done,
   // Configuration
   input wire logic [4:0] primary_addr,
   input wire logic cfg_ren_lock,
   input wire logic cfg_gtl_unlock,
   input wire logic cfg_get_unaddr,
   // Instrument side
   input wire logic srq_req,
   input wire logic [7:0] status_in,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   output logic tx_ready,
   output logic rx_valid,
   output logic rx_last,
   output logic [7:0] rx_data,
   output logic dev_clear,
   output logic trigger,
   // Status
   output logic listen_active,
   output logic talk_active,
   output logic remote,
   output logic lockout,
   output logic panel_lock,
   output logic spoll_mode,
   // Bus driven pins
   output logic [7:0] dio_o,
   output logic dio_oe_n,
   output logic eoi_o,
   output logic eoi_oe_n,
   output logic srq_o,
   output logic srq_oe_n
);
   gbd_pkg::gbd_bus_t bus;
   gbd_pkg::gbd_cmd_t cmd;
   gbd_pkg::gbd_rx_t rx;
   gbd_pkg::gbd_rl_t rl_q;
   gbd_pkg::gbd_rl_t rl_d;
   logic listen_q;
   logic talk_q;
   logic spoll_q;
   logic ren_q;
   logic clear_q;
   logic rx_valid_q;
   logic remote_q;
   logic lockout_q;
   logic trig_q;
   logic lock_panel_q;
   logic srq_q;
   logic [7:0] status_byte;

   // Low level on a line means true
   assign bus.atn = !atn_n;
   assign bus.ren = !ren_n;
   assign bus.ifc = !ifc_n;
   assign bus.eoi = !eoi_n_i;
   assign bus.data = ~dio_n_i;

   gbd_cmd_decode u_decode (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .byte_valid(byte_valid),
      .bus(bus),
      .primary_addr(primary_addr),
      .cmd(cmd),
      .rx(rx)
   );

   // Previous REN level for edge detection
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ren_q <= gbd_pkg::IDLE_RESET;
      end else begin
         ren_q <= bus.ren;
      end
   end

   // Listener flag after this edge; interface clear overrides any byte in flight
   function automatic logic listen_next(input logic cur, input logic ifc, input gbd_pkg::gbd_cmd_t c);
      if (ifc) begin
         listen_next = 1'b0;
      end else if (c == gbd_pkg::CMD_UNL) begin
         listen_next = 1'b0;
      end else if (c == gbd_pkg::CMD_MLA) begin
         listen_next = 1'b1;
      end else begin
         listen_next = cur;
      end
   endfunction

   // Listener addressing
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         listen_q <= gbd_pkg::IDLE_RESET;
      end else begin
         listen_q <= listen_next(listen_q, bus.ifc, cmd);
      end
   end

   // Data gate looks at the listener flag as it will stand, so the pin leaves a flop
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_valid_q <= gbd_pkg::IDLE_RESET;
      end else begin
         rx_valid_q <= byte_valid && !bus.atn && listen_next(listen_q, bus.ifc, cmd);
      end
   end

   // Talker addressing; only one talker may exist, so another talk address idles us
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         talk_q <= gbd_pkg::IDLE_RESET;
      end else if (bus.ifc) begin
         talk_q <= 1'b0;
      end else if (cmd == gbd_pkg::CMD_UNT || cmd == gbd_pkg::CMD_OTA) begin
         talk_q <= 1'b0;
      end else if (cmd == gbd_pkg::CMD_MTA) begin
         talk_q <= 1'b1;
      end
   end

   // Serial poll mode, a universal state
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         spoll_q <= gbd_pkg::IDLE_RESET;
      end else if (bus.ifc || cmd == gbd_pkg::CMD_SPD) begin
         spoll_q <= 1'b0;
      end else if (cmd == gbd_pkg::CMD_SPE) begin
         spoll_q <= 1'b1;
      end
   end

   // Remote/local with lockout
   always_comb begin
      rl_d = rl_q;
      if (!bus.ren) begin
         rl_d = gbd_pkg::RL_LOCAL;
      end else begin
         unique case (rl_q)
            gbd_pkg::RL_LOCAL: begin
               if (!ren_q || cmd == gbd_pkg::CMD_MLA) begin
                  rl_d = gbd_pkg::RL_REMOTE;
               end
               if (cmd == gbd_pkg::CMD_LLO) begin
                  rl_d = gbd_pkg::RL_LOCAL_LOCK;
               end
            end
            gbd_pkg::RL_REMOTE: begin
               if (cmd == gbd_pkg::CMD_LLO) begin
                  rl_d = gbd_pkg::RL_REMOTE_LOCK;
               end else if (cmd == gbd_pkg::CMD_GTL && listen_q) begin
                  rl_d = gbd_pkg::RL_LOCAL;
               end
            end
            gbd_pkg::RL_LOCAL_LOCK: begin
               if (cmd == gbd_pkg::CMD_MLA) begin
                  rl_d = gbd_pkg::RL_REMOTE_LOCK;
               end
            end
            gbd_pkg::RL_REMOTE_LOCK: begin
               if (cmd == gbd_pkg::CMD_GTL && listen_q) begin
                  rl_d = cfg_gtl_unlock ? gbd_pkg::RL_LOCAL : gbd_pkg::RL_LOCAL_LOCK;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rl_q <= gbd_pkg::RL_LOCAL;
      end else begin
         rl_q <= rl_d;
      end
   end

   // True in either lockout state
   function automatic logic rl_locked(input gbd_pkg::gbd_rl_t s);
      rl_locked = (s == gbd_pkg::RL_LOCAL_LOCK) || (s == gbd_pkg::RL_REMOTE_LOCK);
   endfunction

   // Status pins follow the next state so they come straight from flops
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         remote_q <= gbd_pkg::IDLE_RESET;
         lockout_q <= gbd_pkg::IDLE_RESET;
      end else begin
         remote_q <= (rl_d == gbd_pkg::RL_REMOTE) || (rl_d == gbd_pkg::RL_REMOTE_LOCK);
         lockout_q <= rl_locked(rl_d);
      end
   end

   // Panel lock: lockout always, remote only when configured
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         lock_panel_q <= gbd_pkg::IDLE_RESET;
      end else begin
         lock_panel_q <= rl_locked(rl_d) || (rl_d == gbd_pkg::RL_REMOTE && cfg_ren_lock);
      end
   end

   // Device clear pulse; secondary and unknown bytes fall through untouched
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         clear_q <= gbd_pkg::IDLE_RESET;
      end else begin
         clear_q <= (cmd == gbd_pkg::CMD_DCL) || (cmd == gbd_pkg::CMD_SDC && listen_q);
      end
   end

   // Trigger pulse; unaddressed response is an option many instruments offer
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         trig_q <= gbd_pkg::IDLE_RESET;
      end else begin
         trig_q <= (cmd == gbd_pkg::CMD_GET) && (listen_q || cfg_get_unaddr);
      end
   end

   // Service request is open drain: drive low while requesting
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         srq_q <= gbd_pkg::IDLE_RESET;
      end else begin
         srq_q <= srq_req;
      end
   end

   // Poll answer carries the request bit so the controller finds the requester
   always_comb begin
      status_byte = status_in;
      status_byte[gbd_pkg::RQS_BIT] = srq_q;
   end

   gbd_talk_out u_talk (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .talk_active(talk_q),
      .atn(bus.atn),
      .spoll(spoll_q),
      .status_byte(status_byte),
      .tx_valid(tx_valid),
      .tx_data(tx_data),
      .tx_last(tx_last),
      .byte_done(byte_done),
      .tx_ready(tx_ready),
      .dio_o(dio_o),
      .dio_oe_n(dio_oe_n),
      .eoi_o(eoi_o),
      .eoi_oe_n(eoi_oe_n)
   );

   assign rx_valid = rx_valid_q;
   assign rx_last = rx.last;
   assign rx_data = rx.data;
   assign dev_clear = clear_q;
   assign trigger = trig_q;
   assign listen_active = listen_q;
   assign talk_active = talk_q;
   assign remote = remote_q;
   assign lockout = lockout_q;
   assign panel_lock = lock_panel_q;
   assign spoll_mode = spoll_q;
   assign srq_o = 1'b0;
   assign srq_oe_n = !srq_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   ifc_idle_a: assert property (bus.ifc |=> !listen_q && !talk_q)
      else $error("IFC did not idle talker and listener");
   ren_remote_a: assert property ($rose(bus.ren) ##1 bus.ren && !bus.ifc && cmd == gbd_pkg::CMD_NONE |=> remote)
      else $error("REN did not bring remote");
   ren_local_a: assert property (!bus.ren |=> !remote && !lockout)
      else $error("REN false left remote or lockout");
   llo_lock_a: assert property (bus.ren && cmd == gbd_pkg::CMD_LLO |=> lockout && panel_lock)
      else $error("LLO did not lock out");
   spe_enter_a: assert property (!bus.ifc && cmd == gbd_pkg::CMD_SPE |=> spoll_q)
      else $error("SPE did not enter poll mode");
   spd_leave_a: assert property (cmd == gbd_pkg::CMD_SPD |=> !spoll_q)
      else $error("SPD did not leave poll mode");
   sdc_gate_a: assert property (cmd == gbd_pkg::CMD_SDC |=> dev_clear == $past(listen_q))
      else $error("SDC clear not gated by listen");
   dcl_clear_a: assert property (cmd == gbd_pkg::CMD_DCL |=> dev_clear)
      else $error("DCL gave no clear");
   get_trig_a: assert property (cmd == gbd_pkg::CMD_GET && listen_q |=> trigger)
      else $error("GET gave no trigger");
   listen_addr_a: assert property (byte_valid && bus.atn && !bus.ifc && primary_addr <= gbd_pkg::ADDR_MAX &&
      bus.data == (gbd_pkg::LAG_BASE | {3'b000, primary_addr}) ##1 !bus.ifc |=> listen_q)
      else $error("Own listen address not taken");
   talk_addr_a: assert property (byte_valid && bus.atn && !bus.ifc && primary_addr <= gbd_pkg::ADDR_MAX &&
      bus.data == (gbd_pkg::TAG_BASE | {3'b000, primary_addr}) ##1 !bus.ifc |=> talk_q)
      else $error("Own talk address not taken");
   unl_idle_a: assert property (cmd == gbd_pkg::CMD_UNL |=> !listen_q)
      else $error("UNL left listener active");
   unt_idle_a: assert property (cmd == gbd_pkg::CMD_UNT |=> !talk_q)
      else $error("UNT left talker active");
   ignore_cmd_a: assert property ((cmd == gbd_pkg::CMD_OTHER || cmd == gbd_pkg::CMD_SCG) && !bus.ifc &&
      bus.ren == ren_q |=> $stable(listen_q) && $stable(talk_q) && $stable(spoll_q) && $stable(rl_q))
      else $error("Ignored command changed state");
   data_pass_a: assert property (byte_valid && !bus.atn && listen_q && !bus.ifc && !(cmd == gbd_pkg::CMD_UNL)
      |=> rx_valid && rx_data == $past(bus.data))
      else $error("Data byte not passed on");
   rx_gate_a: assert property (rx.valid && !listen_q |-> !rx_valid)
      else $error("Data byte passed while not listening");
   srq_drive_a: assert property (srq_req |=> !srq_oe_n && !srq_o)
      else $error("SRQ not driven");

   listen_cov_c: cover property (cmd == gbd_pkg::CMD_MLA ##[1:8] cmd == gbd_pkg::CMD_SDC ##1 dev_clear);
   poll_cov_c: cover property (spoll_q && talk_q && !bus.atn && !dio_oe_n);
   gtl_cov_c: cover property (remote ##1 cmd == gbd_pkg::CMD_GTL ##1 !remote);
   last_cov_c: cover property (rx_valid && rx_last);
endmodule

// ==== design/gbd_pkg.sv ====
// Shared constants, command classes and carrier structs for the bus command decoder
package gbd_pkg;
   // Address group bases and masks
   localparam logic [7:0] LAG_BASE = 8'h20;
   localparam logic [7:0] TAG_BASE = 8'h40;
   localparam logic [7:0] SCG_BASE = 8'h60;
   localparam logic [7:0] GROUP_MASK = 8'h60;
   localparam logic [7:0] CODE_MASK = 8'h7F;
   localparam logic [4:0] ADDR_FIELD = 5'h1F;
   localparam logic [4:0] ADDR_MAX = 5'h1E;
   // Multiline command codes
   localparam logic [7:0] CODE_GTL = 8'h01;
   localparam logic [7:0] CODE_SDC = 8'h04;
   localparam logic [7:0] CODE_GET = 8'h08;
   localparam logic [7:0] CODE_LLO = 8'h11;
   localparam logic [7:0] CODE_DCL = 8'h14;
   localparam logic [7:0] CODE_SPE = 8'h18;
   localparam logic [7:0] CODE_SPD = 8'h19;
   localparam logic [7:0] CODE_UNL = 8'h3F;
   localparam logic [7:0] CODE_UNT = 8'h5F;
   // Serial poll status byte: request bit position
   localparam int RQS_BIT = 6;
   // Values after reset
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic IDLE_RESET = 1'b0;

   typedef enum logic [3:0] {
      CMD_NONE, CMD_LLO, CMD_DCL, CMD_SPE, CMD_SPD, CMD_SDC, CMD_GTL, CMD_GET,
      CMD_MLA, CMD_MTA, CMD_OTA, CMD_OLA, CMD_UNL, CMD_UNT, CMD_SCG, CMD_OTHER
   } gbd_cmd_t;

   typedef enum logic [1:0] {
      RL_LOCAL, RL_REMOTE, RL_LOCAL_LOCK, RL_REMOTE_LOCK
   } gbd_rl_t;

   // Bus lines as asserted (true) levels after inversion
   typedef struct packed {
      logic atn;
      logic ren;
      logic ifc;
      logic eoi;
      logic [7:0] data;
   } gbd_bus_t;

   // Byte handed to the instrument
   typedef struct packed {
      logic valid;
      logic last;
      logic [7:0] data;
   } gbd_rx_t;

   // Classify a command byte against the device's own primary address
   function automatic gbd_cmd_t cmd_of(input logic [7:0] b, input logic [4:0] addr);
      logic [7:0] c;
      logic own;
      c = b & CODE_MASK;
      own = (addr <= ADDR_MAX) && (c[4:0] == addr);
      unique case (c & GROUP_MASK)
         8'h00, 8'h10: begin
            unique case (c)
               CODE_GTL: cmd_of = CMD_GTL;
               CODE_SDC: cmd_of = CMD_SDC;
               CODE_GET: cmd_of = CMD_GET;
               CODE_LLO: cmd_of = CMD_LLO;
               CODE_DCL: cmd_of = CMD_DCL;
               CODE_SPE: cmd_of = CMD_SPE;
               CODE_SPD: cmd_of = CMD_SPD;
               default: cmd_of = CMD_OTHER;
            endcase
         end
         LAG_BASE: cmd_of = (c == CODE_UNL) ? CMD_UNL : (own ? CMD_MLA : CMD_OLA);
         TAG_BASE: cmd_of = (c == CODE_UNT) ? CMD_UNT : (own ? CMD_MTA : CMD_OTA);
         default: cmd_of = CMD_SCG;
      endcase
   endfunction
endpackage

// ==== design/gbd_cmd_decode.sv ====
// Registered classifier for bytes taken from the data lines
`timescale 1ns/1ps
module gbd_cmd_decode (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Accepted byte
   input wire logic byte_valid,
   input wire gbd_pkg::gbd_bus_t bus,
   input wire logic [4:0] primary_addr,
   // Classified results, one cycle later
   output gbd_pkg::gbd_cmd_t cmd,
   output gbd_pkg::gbd_rx_t rx
);
   gbd_pkg::gbd_cmd_t cmd_q;
   gbd_pkg::gbd_rx_t rx_q;

   // Attention true: interface command or address
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_q <= gbd_pkg::CMD_NONE;
      end else if (byte_valid && bus.atn) begin
         cmd_q <= gbd_pkg::cmd_of(bus.data, primary_addr);
      end else begin
         cmd_q <= gbd_pkg::CMD_NONE;
      end
   end

   // Attention false: programming data, never decoded
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_q <= '0;
      end else begin
         rx_q.valid <= byte_valid && !bus.atn;
         rx_q.last <= byte_valid && !bus.atn && bus.eoi;
         rx_q.data <= (byte_valid && !bus.atn) ? bus.data : rx_q.data;
      end
   end

   assign cmd = cmd_q;
   assign rx = rx_q;
endmodule

// ==== design/gbd_talk_out.sv ====
// Talker output stage driving data lines and end-of-message line
`timescale 1ns/1ps
module gbd_talk_out (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Talker state
   input wire logic talk_active,
   input wire logic atn,
   input wire logic spoll,
   input wire logic [7:0] status_byte,
   // Instrument data source
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   input wire logic byte_done,
   output logic tx_ready,
   // Bus pins, output levels are wire levels
   output logic [7:0] dio_o,
   output logic dio_oe_n,
   output logic eoi_o,
   output logic eoi_oe_n
);
   logic drive;
   assign drive = talk_active && !atn && (spoll || tx_valid);

   // Bus lines are active low, so true data is driven as a low level
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         dio_o <= 8'hFF;
         dio_oe_n <= 1'b1;
         eoi_o <= 1'b1;
         eoi_oe_n <= 1'b1;
      end else begin
         dio_o <= drive ? ~(spoll ? status_byte : tx_data) : 8'hFF;
         dio_oe_n <= !drive;
         eoi_o <= !(drive && !spoll && tx_last);
         eoi_oe_n <= !drive;
      end
   end

   // Completed data bytes release the next one; poll bytes are not consumed
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_ready <= 1'b0;
      end else begin
         tx_ready <= byte_done && talk_active && !atn && !spoll && tx_valid;
      end
   end
endmodule

// ==== tb/gbd_ctl_model.sv ====
// Controller model: drives management and data lines, accepts bytes from the talker
`timescale 1ns/1ps
module gbd_ctl_model (
   // Clock
   input wire logic ref_clk,
   // Lines driven by the controller, wire levels
   output logic atn_n,
   output logic ren_n,
   output logic ifc_n,
   output logic eoi_n_i,
   output logic [7:0] dio_n_i,
   output logic byte_valid,
   output logic byte_done,
   // Talker lines from the device
   input wire logic [7:0] dio_o,
   input wire logic dio_oe_n,
   input wire logic eoi_o,
   // Last byte accepted from the device
   output logic [7:0] got_dio,
   output logic got_eoi,
   output logic got_ok
);
   initial begin
      atn_n = 1'b1;
      ren_n = 1'b1;
      ifc_n = 1'b1;
      eoi_n_i = 1'b1;
      dio_n_i = 8'hFF;
      byte_valid = 1'b0;
      byte_done = 1'b0;
      got_dio = 8'h00;
      got_eoi = 1'b0;
      got_ok = 1'b0;
   end
   // One byte, qualified by a one-cycle byte_valid
   task automatic put(input logic atn, input logic [7:0] b, input logic eoi);
      @(posedge ref_clk);
      atn_n <= ~atn;
      dio_n_i <= ~b;
      eoi_n_i <= ~eoi;
      byte_valid <= 1'b1;
      @(posedge ref_clk);
      byte_valid <= 1'b0;
      // Released lines return to the pull-up level
      dio_n_i <= 8'hFF;
      eoi_n_i <= 1'b1;
   endtask
   task automatic set_atn(input logic v);
      @(posedge ref_clk);
      atn_n <= ~v;
   endtask
   task automatic set_ren(input logic v);
      @(posedge ref_clk);
      ren_n <= ~v;
   endtask
   task automatic pulse_ifc();
      @(posedge ref_clk);
      ifc_n <= 1'b0;
      @(posedge ref_clk);
      ifc_n <= 1'b1;
   endtask
   // Slow listener: waits before accepting, so the talker must hold its byte
   task automatic accept(input int slow);
      int n;
      n = 0;
      while (dio_oe_n !== 1'b0 && n < 50) begin
         @(posedge ref_clk);
         n++;
      end
      repeat (slow) @(posedge ref_clk);
      got_dio = dio_o;
      got_eoi = eoi_o;
      got_ok = (dio_oe_n === 1'b0);
      byte_done <= 1'b1;
      @(posedge ref_clk);
      byte_done <= 1'b0;
   endtask
endmodule

// ==== tb/gbd_bus_command_decoder_tb.sv ====
// Self-checking bench for the bus command decoder
`timescale 1ns/1ps
module gbd_bus_command_decoder_tb;
   logic ref_clk, reset_n, atn_n, ren_n, ifc_n, eoi_n_i, byte_valid, byte_done;
   logic [7:0] dio_n_i, status_in, tx_data, rx_data, dio_o, got_dio, rx_byte;
   logic [4:0] primary_addr;
   logic cfg_ren_lock, cfg_gtl_unlock, cfg_get_unaddr, srq_req, tx_valid, tx_last, tx_ready;
   logic rx_valid, rx_last, dev_clear, trigger, listen_active, talk_active, remote, lockout;
   logic panel_lock, spoll_mode, dio_oe_n, eoi_o, eoi_oe_n, srq_o, srq_oe_n, got_eoi, got_ok;
   logic seen_clr = 1'b0, seen_trig = 1'b0, rx_eoi = 1'b0;
   logic [7:0] rx_cnt = 8'h00;
   int err_total, n_tests, cyc;

   gbd_bus_command_decoder u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .atn_n(atn_n), .ren_n(ren_n),
      .ifc_n(ifc_n), .eoi_n_i(eoi_n_i), .dio_n_i(dio_n_i), .byte_valid(byte_valid), .byte_done(byte_done),
      .primary_addr(primary_addr), .cfg_ren_lock(cfg_ren_lock), .cfg_gtl_unlock(cfg_gtl_unlock),
      .cfg_get_unaddr(cfg_get_unaddr), .srq_req(srq_req), .status_in(status_in), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_last(rx_last),
      .rx_data(rx_data), .dev_clear(dev_clear), .trigger(trigger), .listen_active(listen_active),
      .talk_active(talk_active), .remote(remote), .lockout(lockout), .panel_lock(panel_lock),
      .spoll_mode(spoll_mode), .dio_o(dio_o), .dio_oe_n(dio_oe_n), .eoi_o(eoi_o), .eoi_oe_n(eoi_oe_n),
      .srq_o(srq_o), .srq_oe_n(srq_oe_n));
   gbd_ctl_model u_ctl (.ref_clk(ref_clk), .atn_n(atn_n), .ren_n(ren_n), .ifc_n(ifc_n),
      .eoi_n_i(eoi_n_i), .dio_n_i(dio_n_i), .byte_valid(byte_valid), .byte_done(byte_done),
      .dio_o(dio_o), .dio_oe_n(dio_oe_n), .eoi_o(eoi_o), .got_dio(got_dio), .got_eoi(got_eoi),
      .got_ok(got_ok));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // Pulses last one cycle, so they are caught here and judged later; each new byte re-arms them
   always @(posedge ref_clk) begin
      seen_clr <= (dev_clear === 1'b1) || (seen_clr && byte_valid !== 1'b1);
      seen_trig <= (trigger === 1'b1) || (seen_trig && byte_valid !== 1'b1);
      if (rx_valid === 1'b1) begin
         rx_cnt <= rx_cnt + 8'h01;
         rx_byte <= rx_data;
         rx_eoi <= rx_last;
      end
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         test_done();
      end
   end

   task automatic test_done();
      $display("Checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Command byte with attention true; state flags settle two edges after the byte is taken
   task automatic cmd(input logic [7:0] b);
      @(posedge ref_clk);
      u_ctl.put(1'b1, b, 1'b0);
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   task automatic t_reset();
      chk("listen", 8'h00, listen_active);
      chk("remote", 8'h00, remote);
      chk("dio_oe_n", 8'h01, dio_oe_n);
      chk("srq_oe_n", 8'h01, srq_oe_n);
   endtask
   task automatic t_listen();
      u_ctl.set_ren(1'b1);
      wait_n(3);
      chk("remote", 8'h01, remote);
      cmd(8'h28);
      chk("listen other", 8'h00, listen_active);
      cmd(8'h27);
      chk("listen own", 8'h01, listen_active);
   endtask
   task automatic t_data();
      u_ctl.put(1'b0, 8'h41, 1'b0);
      u_ctl.put(1'b0, 8'h42, 1'b1);
      wait_n(2);
      chk("rx count", 8'h02, rx_cnt);
      chk("rx byte", 8'h42, rx_byte);
      chk("rx last", 8'h01, rx_eoi);
      cmd(8'h41);
      chk("rx count atn", 8'h02, rx_cnt);
   endtask
   task automatic t_lock();
      cmd(gbd_pkg::CODE_LLO);
      chk("lockout", 8'h01, lockout);
      chk("panel", 8'h01, panel_lock);
      cmd(8'h05);
      cmd(8'h67);
      chk("listen kept", 8'h01, listen_active);
      chk("remote kept", 8'h01, remote);
      cmd(gbd_pkg::CODE_GTL);
      chk("remote gtl", 8'h00, remote);
      chk("lockout gtl", 8'h01, lockout);
   endtask
   task automatic t_clear();
      cmd(gbd_pkg::CODE_SDC);
      chk("sdc listening", 8'h01, seen_clr);
      cmd(gbd_pkg::CODE_UNL);
      chk("unlisten", 8'h00, listen_active);
      cmd(gbd_pkg::CODE_SDC);
      chk("sdc idle", 8'h00, seen_clr);
      cmd(gbd_pkg::CODE_DCL);
      chk("dcl", 8'h01, seen_clr);
   endtask
   task automatic t_trig();
      cmd(gbd_pkg::CODE_GET);
      chk("get unaddr off", 8'h00, seen_trig);
      @(posedge ref_clk);
      cfg_get_unaddr <= 1'b1;
      cmd(gbd_pkg::CODE_GET);
      chk("get unaddr on", 8'h01, seen_trig);
   endtask
   task automatic t_talk();
      int n;
      cmd(8'h47);
      chk("talk own", 8'h01, talk_active);
      u_ctl.set_atn(1'b0);
      @(posedge ref_clk);
      tx_valid <= 1'b1;
      tx_data <= 8'hA5;
      tx_last <= 1'b1;
      u_ctl.accept(3);
      n = 0;
      while (tx_ready !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         n++;
      end
      tx_valid <= 1'b0;
      chk("tx ready", 8'h01, tx_ready);
      chk("talk driven", 8'h01, got_ok);
      chk("talk dio", 8'h5A, got_dio);
      chk("talk eoi", 8'h00, got_eoi);
   endtask
   task automatic t_poll();
      @(posedge ref_clk);
      srq_req <= 1'b1;
      status_in <= 8'h05;
      cmd(gbd_pkg::CODE_SPE);
      chk("spoll on", 8'h01, spoll_mode);
      chk("srq", 8'h00, srq_oe_n);
      u_ctl.set_atn(1'b0);
      wait_n(3);
      chk("poll dio", 8'hBA, dio_o);
      chk("poll eoi", 8'h01, eoi_o);
      chk("poll eoi_oe_n", 8'h00, eoi_oe_n);
      chk("srq level", 8'h00, srq_o);
      cmd(gbd_pkg::CODE_SPD);
      chk("spoll off", 8'h00, spoll_mode);
   endtask
   task automatic t_idle();
      cmd(gbd_pkg::CODE_UNT);
      chk("untalk", 8'h00, talk_active);
      cmd(8'h27);
      cmd(8'h47);
      u_ctl.pulse_ifc();
      wait_n(2);
      chk("ifc listen", 8'h00, listen_active);
      chk("ifc talk", 8'h00, talk_active);
   endtask
   task automatic t_addr();
      @(posedge ref_clk);
      primary_addr <= 5'h1E;
      cmd(8'h3E);
      chk("listen 30", 8'h01, listen_active);
      cmd(gbd_pkg::CODE_UNL);
      @(posedge ref_clk);
      primary_addr <= 5'h00;
      cmd(8'h20);
      chk("listen 0", 8'h01, listen_active);
      u_ctl.set_ren(1'b0);
      wait_n(2);
      chk("ren off", 8'h00, remote);
   endtask
   task automatic t_cfg();
      @(posedge ref_clk);
      cfg_ren_lock <= 1'b0;
      cfg_gtl_unlock <= 1'b1;
      u_ctl.set_ren(1'b1);
      wait_n(2);
      chk("remote unlocked", 8'h01, remote);
      chk("panel free", 8'h00, panel_lock);
      cmd(gbd_pkg::CODE_LLO);
      cmd(gbd_pkg::CODE_GTL);
      chk("gtl unlock", 8'h00, lockout);
   endtask

   initial begin
      reset_n = 1'b0;
      primary_addr = 5'h07;
      cfg_ren_lock = 1'b1;
      cfg_gtl_unlock = 1'b0;
      cfg_get_unaddr = 1'b0;
      srq_req = 1'b0;
      status_in = 8'h00;
      tx_valid = 1'b0;
      tx_data = 8'h00;
      tx_last = 1'b0;
      err_total = 0;
      n_tests = 0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      wait_n(1);
      t_reset();
      t_listen();
      t_data();
      t_lock();
      t_clear();
      t_trig();
      t_talk();
      t_poll();
      t_idle();
      t_addr();
      t_cfg();
      test_done();
   end
endmodule
